// >>> pkg/t2cr_cfg.svh
// Offsets, field positions, reset values and timing counts of the timer block.
// Assumes inclusion by bare name from any file that needs the constants.
`ifndef T2CR_CFG_SVH
`define T2CR_CFG_SVH

// Register byte offsets on the APB word map
`define T2CR_OFS_CTRL 8'h00
`define T2CR_OFS_COUNT 8'h04
`define T2CR_OFS_CAPREL 8'h08
`define T2CR_OFS_STATUS 8'h0C
`define T2CR_OFS_MASK 8'h10

// Control register bit positions
`define T2CR_B_OVF 7
`define T2CR_B_EXT 6
`define T2CR_B_RXSEL 5
`define T2CR_B_TXSEL 4
`define T2CR_B_EXTEN 3
`define T2CR_B_RUN 2
`define T2CR_B_CTRSEL 1
`define T2CR_B_CPRL 0

// Status and mask bit positions
`define T2CR_S_OVF 0
`define T2CR_S_EXT 1

// Reset values
`define T2CR_CTRL_RST 6'h00
`define T2CR_COUNT_RST 16'h0000
`define T2CR_CAPREL_RST 16'h0000
`define T2CR_MASK_RST 2'h0

// Clocks per machine cycle and the terminal count
`define T2CR_MC_DIV 4'hC
`define T2CR_COUNT_MAX 16'hFFFF

`endif

// >>> pkg/t2cr_pkg.sv
// Types shared by the timer block modules.
// Assumes the constants header is on the include path.
package t2cr_pkg;

    typedef enum logic [1:0] {
        T2CR_OFF,
        T2CR_RELOAD,
        T2CR_CAPTURE,
        T2CR_BAUD
    } t2cr_mode_t;

    typedef struct packed {
        logic [5:0] ctrl;
        logic ovf_flag;
        logic ext_flag;
        logic [15:0] count;
        logic [15:0] caprel;
        logic [1:0] mask;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic irq;
        logic rx_tick;
        logic tx_tick;
    } t2cr_core_t;

    typedef struct packed {
        logic [1:0] s1;
        logic [1:0] s2;
        logic [1:0] s3;
        logic [1:0] level;
        logic [1:0] fall;
    } t2cr_sync_t;

    typedef struct packed {
        logic [3:0] cnt;
        logic tick;
    } t2cr_presc_t;

endpackage : t2cr_pkg

// >>> pkg/t2cr_evt_if.sv
// Event signals from the pin synchroniser and the prescaler to the timer core.
// Assumes all three parties share one clock.
`timescale 1ns/1ps
interface t2cr_evt_if;
    logic count_fall;
    logic trig_fall;
    logic mc_tick;

    modport sync_mp (output count_fall, output trig_fall);
    modport presc_mp (output mc_tick);
    modport core_mp (input count_fall, input trig_fall, input mc_tick);
endinterface : t2cr_evt_if

// >>> rtl/t2cr_presc.sv
// Machine-cycle prescaler: one tick every twelve clocks.
// Assumes a free-running clock and an asynchronous active-low reset.
`timescale 1ns/1ps
`include "t2cr_cfg.svh"
module t2cr_presc (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_b_in,
    // Tick out
    t2cr_evt_if.presc_mp evt
);
    import t2cr_pkg::*;

    t2cr_presc_t st;
    t2cr_presc_t next_st;

    always_comb begin
        next_st = st;
        next_st.tick = 1'b0;
        if (st.cnt == `T2CR_MC_DIV - 4'h1) begin
            next_st.cnt = 4'h0;
            next_st.tick = 1'b1;
        end else begin
            next_st.cnt = st.cnt + 4'h1;
        end
    end

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign evt.mc_tick = st.tick;

    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!rst_b_in);

    a_tick_spacing: assert property (st.tick |=> !st.tick [*8]) else $error("tick too close");

endmodule : t2cr_presc

// >>> rtl/t2cr_edge_sync.sv
// Three-stage synchroniser and falling-edge detector for the two pins.
// Assumes pins are asynchronous to the clock.
`timescale 1ns/1ps
module t2cr_edge_sync (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_b_in,
    // Pins: bit 0 count pin, bit 1 trigger pin
    input wire logic [1:0] pin_in,
    // Edge events
    t2cr_evt_if.sync_mp evt
);
    import t2cr_pkg::*;

    t2cr_sync_t st;
    t2cr_sync_t next_st;

    always_comb begin
        next_st = st;
        next_st.s1 = pin_in;
        next_st.s2 = st.s1;
        next_st.s3 = st.s2;
        for (int i = 0; i < 2; i++) begin
            next_st.fall[i] = 1'b0;
            // Change counts once stages two and three agree
            if (st.s2[i] == st.s3[i]) begin
                next_st.level[i] = st.s3[i];
                next_st.fall[i] = st.level[i] & ~st.s3[i];
            end
        end
    end

    // Idle level of both pins is high
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            st <= '{s1: 2'h3, s2: 2'h3, s3: 2'h3, level: 2'h3, fall: 2'h0};
        end else begin
            st <= next_st;
        end
    end

    assign evt.count_fall = st.fall[0];
    assign evt.trig_fall = st.fall[1];

    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!rst_b_in);

    a_fall_single: assert property (st.fall[1] |=> !st.fall[1]) else $error("double edge");

endmodule : t2cr_edge_sync

// >>> rtl/t2cr_timer.sv
// Sixteen-bit capture / auto-reload / baud timer with an APB register slave.
// Assumes an APB master on clk_in; count and trigger pins are asynchronous.
//
// Design decisions made here: the APB register port and the register addresses.
`timescale 1ns/1ps
`include "t2cr_cfg.svh"

// Summary of operation
// - Timer counts only while run control is 1; off otherwise.
// - Counter select 1 counts count-pin falls; 0 counts machine cycles (clock/12).
// - External enable 0 ignores trigger pin: no capture, reload or flag.
// - Trigger events act only when neither serial clock select is set.
// - Mode: serial select gives baud; else capture/reload select picks mode.
// - With a serial select set, capture/reload select ignored; reload on overflow.
// - Capture mode counts freely; overflow sets the overflow flag.
// - Enabled trigger fall in capture mode copies count into capture register.
// - Enabled trigger fall in capture mode sets the external flag.
// - Overflow and external flags share one interrupt output.
// - Auto-reload: rollover sets overflow flag and reloads count.
// - Auto-reload: enabled trigger fall forces early reload, sets external flag.
// - Baud mode active when receive, transmit or both selects are 1.
// - Overflow flag sticky until cleared; never set in baud mode.
// - In baud mode overflow pulses go to serial receive/transmit clocks.
module t2cr_timer (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_b_in,
    // APB slave
    input wire logic [7:0] paddr_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [31:0] pwdata_in,
    input wire logic [3:0] pstrb_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    // Pins
    input wire logic count_pin_in,
    input wire logic trigger_pin_in,
    // Serial port clocks and interrupt
    output logic rx_baud_tick_out,
    output logic tx_baud_tick_out,
    output logic irq_out
);
    import t2cr_pkg::*;

    t2cr_core_t st;
    t2cr_core_t next_st;
    t2cr_mode_t mode;

    logic baud_sel;
    logic inc;
    logic ovf;
    logic ext_ev;
    logic apb_setup;
    logic apb_wr;
    logic wr_ctrl;
    logic wr_count;
    logic wr_caprel;
    logic wr_status;
    logic wr_mask;
    logic [7:0] ctrl_view;
    logic [1:0] status_view;

    t2cr_evt_if evt ();

    t2cr_edge_sync u_sync (
        .clk_in(clk_in),
        .rst_b_in(rst_b_in),
        .pin_in({trigger_pin_in, count_pin_in}),
        .evt(evt.sync_mp)
    );

    t2cr_presc u_presc (
        .clk_in(clk_in),
        .rst_b_in(rst_b_in),
        .evt(evt.presc_mp)
    );

    // Control byte as software sees it
    assign ctrl_view = {st.ovf_flag, st.ext_flag, st.ctrl};
    assign status_view = {st.ext_flag, st.ovf_flag};

    // APB decode
    assign apb_setup = psel_in & ~penable_in;
    assign apb_wr = psel_in & penable_in & st.pready & pwrite_in;
    assign wr_ctrl = apb_wr & (paddr_in == `T2CR_OFS_CTRL);
    assign wr_count = apb_wr & (paddr_in == `T2CR_OFS_COUNT);
    assign wr_caprel = apb_wr & (paddr_in == `T2CR_OFS_CAPREL);
    assign wr_status = apb_wr & (paddr_in == `T2CR_OFS_STATUS);
    assign wr_mask = apb_wr & (paddr_in == `T2CR_OFS_MASK);

    assign baud_sel = st.ctrl[`T2CR_B_RXSEL] | st.ctrl[`T2CR_B_TXSEL];

    // Mode decode
    always_comb begin
        if (!st.ctrl[`T2CR_B_RUN]) begin
            mode = T2CR_OFF;
        end else if (baud_sel) begin
            mode = T2CR_BAUD;
        end else if (st.ctrl[`T2CR_B_CPRL]) begin
            mode = T2CR_CAPTURE;
        end else begin
            mode = T2CR_RELOAD;
        end
    end

    // Count source and events
    always_comb begin
        inc = 1'b0;
        ext_ev = 1'b0;
        case (mode)
            T2CR_OFF: begin
                inc = 1'b0;
            end
            T2CR_RELOAD, T2CR_CAPTURE: begin
                inc = st.ctrl[`T2CR_B_CTRSEL] ? evt.count_fall : evt.mc_tick;
                ext_ev = st.ctrl[`T2CR_B_EXTEN] & evt.trig_fall;
            end
            T2CR_BAUD: begin
                inc = st.ctrl[`T2CR_B_CTRSEL] ? evt.count_fall : evt.mc_tick;
            end
            default: begin
                inc = 1'b0;
            end
        endcase
    end

    assign ovf = inc & (st.count == `T2CR_COUNT_MAX);

    always_comb begin
        next_st = st;
        next_st.pready = 1'b0;
        next_st.pslverr = 1'b0;
        next_st.rx_tick = 1'b0;
        next_st.tx_tick = 1'b0;

        // Read data and ready are set up in the setup cycle
        if (apb_setup) begin
            next_st.pready = 1'b1;
            case (paddr_in)
                `T2CR_OFS_CTRL: next_st.prdata = {24'h000000, ctrl_view};
                `T2CR_OFS_COUNT: next_st.prdata = {16'h0000, st.count};
                `T2CR_OFS_CAPREL: next_st.prdata = {16'h0000, st.caprel};
                `T2CR_OFS_STATUS: next_st.prdata = {30'h00000000, status_view};
                `T2CR_OFS_MASK: next_st.prdata = {30'h00000000, st.mask};
                default: begin
                    next_st.prdata = 32'h00000000;
                    next_st.pslverr = 1'b1;
                end
            endcase
        end

        // Software writes; flag bits of the control byte are read-only
        if (wr_ctrl && pstrb_in[0]) begin
            next_st.ctrl = pwdata_in[5:0];
        end
        if (wr_caprel) begin
            if (pstrb_in[0]) begin
                next_st.caprel[7:0] = pwdata_in[7:0];
            end
            if (pstrb_in[1]) begin
                next_st.caprel[15:8] = pwdata_in[15:8];
            end
        end
        if (wr_mask && pstrb_in[0]) begin
            next_st.mask = pwdata_in[1:0];
        end
        // Write one to clear; any set below wins
        if (wr_status && pstrb_in[0]) begin
            if (pwdata_in[`T2CR_S_OVF]) begin
                next_st.ovf_flag = 1'b0;
            end
            if (pwdata_in[`T2CR_S_EXT]) begin
                next_st.ext_flag = 1'b0;
            end
        end

        // Counting
        if (inc) begin
            next_st.count = st.count + 16'h0001;
        end
        case (mode)
            T2CR_RELOAD: begin
                if (ovf || ext_ev) begin
                    next_st.count = st.caprel;
                end
                if (ovf) begin
                    next_st.ovf_flag = 1'b1;
                end
                if (ext_ev) begin
                    next_st.ext_flag = 1'b1;
                end
            end
            T2CR_CAPTURE: begin
                if (ovf) begin
                    next_st.ovf_flag = 1'b1;
                end
                if (ext_ev) begin
                    next_st.caprel = st.count;
                    next_st.ext_flag = 1'b1;
                end
            end
            T2CR_BAUD: begin
                if (ovf) begin
                    next_st.count = st.caprel;
                    next_st.rx_tick = st.ctrl[`T2CR_B_RXSEL];
                    next_st.tx_tick = st.ctrl[`T2CR_B_TXSEL];
                end
            end
            default: begin
                next_st.count = next_st.count;
            end
        endcase

        // A software load of the count wins over counting
        if (wr_count) begin
            if (pstrb_in[0]) begin
                next_st.count[7:0] = pwdata_in[7:0];
            end
            if (pstrb_in[1]) begin
                next_st.count[15:8] = pwdata_in[15:8];
            end
        end

        // One shared request line
        next_st.irq = (next_st.ovf_flag & next_st.mask[`T2CR_S_OVF])
                    | (next_st.ext_flag & next_st.mask[`T2CR_S_EXT]);
    end

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            st <= '{ctrl: `T2CR_CTRL_RST, ovf_flag: 1'b0, ext_flag: 1'b0,
                    count: `T2CR_COUNT_RST, caprel: `T2CR_CAPREL_RST,
                    mask: `T2CR_MASK_RST, pready: 1'b0, pslverr: 1'b0,
                    prdata: 32'h00000000, irq: 1'b0, rx_tick: 1'b0, tx_tick: 1'b0};
        end else begin
            st <= next_st;
        end
    end

    assign prdata_out = st.prdata;
    assign pready_out = st.pready;
    assign pslverr_out = st.pslverr;
    assign rx_baud_tick_out = st.rx_tick;
    assign tx_baud_tick_out = st.tx_tick;
    assign irq_out = st.irq;

    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!rst_b_in);

    a_off_count_hold: assert property (
        (mode == T2CR_OFF && !wr_count) |=> (st.count == $past(st.count)))
        else $error("count moved while stopped");

    a_mc_count_inc: assert property (
        (mode == T2CR_RELOAD && !st.ctrl[`T2CR_B_CTRSEL] && evt.mc_tick
         && st.count != `T2CR_COUNT_MAX && !ext_ev && !wr_count)
        |=> (st.count == $past(st.count) + 16'h0001))
        else $error("machine cycle not counted");

    a_ext_disabled_quiet: assert property (
        (!st.ctrl[`T2CR_B_EXTEN]) |=> !$rose(st.ext_flag))
        else $error("external flag set while disabled");

    a_baud_no_ext: assert property (
        (mode == T2CR_BAUD) |=> !$rose(st.ext_flag))
        else $error("trigger acted in baud mode");

    a_baud_no_ovf: assert property (
        baud_sel |=> !$rose(st.ovf_flag))
        else $error("overflow flag set in baud mode");

    a_baud_reload: assert property (
        (mode == T2CR_BAUD && ovf && !wr_count) |=> (st.count == $past(st.caprel)))
        else $error("no reload on baud overflow");

    a_capture_copy: assert property (
        (mode == T2CR_CAPTURE && ext_ev) |=> (st.caprel == $past(st.count)) && st.ext_flag)
        else $error("capture missed");

    a_reload_early: assert property (
        (mode == T2CR_RELOAD && ext_ev && !wr_count)
        |=> (st.count == $past(st.caprel)) && st.ext_flag)
        else $error("early reload missed");

    a_ovf_flag_set: assert property (
        (ovf && mode != T2CR_BAUD) |=> st.ovf_flag)
        else $error("overflow flag not set");

    a_irq_shared: assert property (
        irq_out == ((st.ovf_flag & st.mask[0]) | (st.ext_flag & st.mask[1])))
        else $error("interrupt line mismatch");

    a_baud_tick_route: assert property (
        (mode == T2CR_BAUD && ovf && st.ctrl[`T2CR_B_TXSEL]) |=> tx_baud_tick_out)
        else $error("transmit clock pulse missing");

    a_pin_count_inc: assert property (
        (mode == T2CR_CAPTURE && st.ctrl[`T2CR_B_CTRSEL] && evt.count_fall && !ovf && !wr_count)
        |=> (st.count == $past(st.count) + 16'h0001))
        else $error("count pin fall not counted");

    a_capture_rollover: assert property (
        (mode == T2CR_CAPTURE && ovf && !wr_count) |=> (st.count == 16'h0000))
        else $error("capture mode did not roll over to zero");

    a_ovf_flag_hold: assert property (
        (st.ovf_flag && !(wr_status && pstrb_in[0] && pwdata_in[`T2CR_S_OVF])) |=> st.ovf_flag)
        else $error("overflow flag dropped without a clear");

    a_ext_flag_hold: assert property (
        (st.ext_flag && !(wr_status && pstrb_in[0] && pwdata_in[`T2CR_S_EXT])) |=> st.ext_flag)
        else $error("external flag dropped without a clear");

    a_off_no_ext: assert property (
        (mode == T2CR_OFF) |=> !$rose(st.ext_flag))
        else $error("trigger acted while stopped");

    a_reload_caprel_hold: assert property (
        (mode == T2CR_RELOAD && !wr_caprel) |=> (st.caprel == $past(st.caprel)))
        else $error("reload value changed in reload mode");

    a_baud_no_capture: assert property (
        (mode == T2CR_BAUD && !wr_caprel) |=> (st.caprel == $past(st.caprel)))
        else $error("capture happened in baud mode");

    a_baud_tick_rx: assert property (
        (mode == T2CR_BAUD && ovf && st.ctrl[`T2CR_B_RXSEL]) |=> rx_baud_tick_out)
        else $error("receive clock pulse missing");

    a_tick_only_baud: assert property (
        (mode != T2CR_BAUD) |=> (!rx_baud_tick_out && !tx_baud_tick_out))
        else $error("serial clock pulse outside baud mode");

    c_capture_event: cover property (mode == T2CR_CAPTURE && ext_ev);
    c_reload_overflow: cover property (mode == T2CR_RELOAD && ovf);
    c_baud_tick: cover property (rx_baud_tick_out);
    c_irq_raised: cover property ($rose(irq_out));
    c_reload_early: cover property (mode == T2CR_RELOAD && ext_ev);

endmodule : t2cr_timer

// >>> verification/t2cr_pin_model.sv
// Model of the count and trigger pins that drive the timer.
// Assumes one clock shared with the bench; both pins idle high.
`timescale 1ns/1ps
module t2cr_pin_model (
    // Clock
    input wire logic clk_in,
    // Pins
    output logic count_pin_out,
    output logic trigger_pin_out
);
    initial begin
        count_pin_out = 1'b1;
        trigger_pin_out = 1'b1;
    end

    // One falling edge; each level held for hold clocks, at least 3
    task automatic fall(input logic trig, input int hold);
        @(posedge clk_in);
        if (trig) begin
            trigger_pin_out <= 1'b0;
        end else begin
            count_pin_out <= 1'b0;
        end
        repeat (hold) @(posedge clk_in);
        trigger_pin_out <= 1'b1;
        count_pin_out <= 1'b1;
        repeat (hold) @(posedge clk_in);
    endtask : fall
endmodule : t2cr_pin_model

// >>> verification/t2cr_timer_tb.sv
// Self-checking bench for the timer: APB tasks plus pin model events.
// Assumes the constants header on the include path and a 25 MHz clock.
`timescale 1ns/1ps
`include "t2cr_cfg.svh"
module t2cr_timer_tb;
    logic clk_in;
    logic rst_b_in;
    logic [7:0] paddr;
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic count_pin;
    logic trigger_pin;
    logic rx_tick;
    logic tx_tick;
    logic irq;
    int err_count;
    int checks;
    int rx_n = 0;
    int tx_n = 0;
    int rx0;
    int tx0;
    logic [31:0] rd;
    logic er;
    logic [7:0] sels [3] = '{8'h20, 8'h10, 8'h30};

    t2cr_timer t2cr_timer_inst (
        .clk_in(clk_in), .rst_b_in(rst_b_in), .paddr_in(paddr), .psel_in(psel),
        .penable_in(penable), .pwrite_in(pwrite), .pwdata_in(pwdata),
        .pstrb_in(4'hF), .prdata_out(prdata), .pready_out(pready),
        .pslverr_out(pslverr), .count_pin_in(count_pin),
        .trigger_pin_in(trigger_pin), .rx_baud_tick_out(rx_tick),
        .tx_baud_tick_out(tx_tick), .irq_out(irq)
    );

    t2cr_pin_model t2cr_pin_model_inst (
        .clk_in(clk_in),
        .count_pin_out(count_pin),
        .trigger_pin_out(trigger_pin)
    );

    initial begin
        clk_in = 1'b0;
        forever #20 clk_in = ~clk_in;
    end

    always @(posedge clk_in) begin
        if (rx_tick === 1'b1) begin
            rx_n <= rx_n + 1;
        end
        if (tx_tick === 1'b1) begin
            tx_n <= tx_n + 1;
        end
    end

    task automatic finish_test;
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : finish_test

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // One APB transfer; waits for pready under a bound
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd);
        int n;
        @(posedge clk_in);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= w;
        pwdata <= wd;
        @(posedge clk_in);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_in);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            err_count++;
            finish_test();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : xfer

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask : wr

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0);
        check(rd, exp);
    endtask : rd_chk

    task automatic pulse(input logic trig, input int n);
        repeat (n) t2cr_pin_model_inst.fall(trig, 4);
    endtask : pulse

    task automatic irq_chk(input logic exp);
        repeat (2) @(posedge clk_in);
        check({31'h0, irq}, {31'h0, exp});
    endtask : irq_chk

    initial begin
        rst_b_in = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        err_count = 0;
        checks = 0;
        repeat (2) @(posedge clk_in);
        rst_b_in <= 1'b1;
        rd_chk(`T2CR_OFS_CTRL, 32'h0);
        rd_chk(`T2CR_OFS_COUNT, 32'h0);
        rd_chk(`T2CR_OFS_CAPREL, 32'h0);
        rd_chk(`T2CR_OFS_MASK, 32'h0);
        xfer(1'b0, 8'h14, 32'h0);
        check({31'h0, er}, 32'h1);
        check(rd, 32'h0);
        $display("test reset done");
        // Stopped timer ignores both pins
        wr(`T2CR_OFS_CTRL, 32'h0B);
        pulse(1'b0, 3);
        pulse(1'b1, 1);
        rd_chk(`T2CR_OFS_COUNT, 32'h0);
        rd_chk(`T2CR_OFS_STATUS, 32'h0);
        $display("test stopped done");
        // About 243 clocks of timer mode
        wr(`T2CR_OFS_CTRL, 32'h04);
        repeat (240) @(posedge clk_in);
        wr(`T2CR_OFS_CTRL, 32'h00);
        xfer(1'b0, `T2CR_OFS_COUNT, 32'h0);
        check(32'(rd >= 19 && rd <= 21), 32'h1);
        $display("test timer done");
        // Capture mode counting pin falls through the rollover
        wr(`T2CR_OFS_COUNT, 32'hFFFE);
        wr(`T2CR_OFS_MASK, 32'h1);
        wr(`T2CR_OFS_CTRL, 32'h07);
        pulse(1'b0, 3);
        wr(`T2CR_OFS_CTRL, 32'h00);
        rd_chk(`T2CR_OFS_COUNT, 32'h0001);
        rd_chk(`T2CR_OFS_STATUS, 32'h1);
        rd_chk(`T2CR_OFS_CTRL, 32'h80);
        irq_chk(1'b1);
        wr(`T2CR_OFS_MASK, 32'h0);
        irq_chk(1'b0);
        wr(`T2CR_OFS_STATUS, 32'h1);
        rd_chk(`T2CR_OFS_STATUS, 32'h0);
        $display("test overflow done");
        // Trigger ignored, then captured
        wr(`T2CR_OFS_COUNT, 32'h0050);
        wr(`T2CR_OFS_MASK, 32'h2);
        wr(`T2CR_OFS_CTRL, 32'h07);
        pulse(1'b1, 1);
        rd_chk(`T2CR_OFS_CAPREL, 32'h0);
        rd_chk(`T2CR_OFS_STATUS, 32'h0);
        wr(`T2CR_OFS_CTRL, 32'h0F);
        t2cr_pin_model_inst.fall(1'b1, 8);
        rd_chk(`T2CR_OFS_CAPREL, 32'h0050);
        rd_chk(`T2CR_OFS_STATUS, 32'h2);
        irq_chk(1'b1);
        wr(`T2CR_OFS_STATUS, 32'h2);
        rd_chk(`T2CR_OFS_STATUS, 32'h0);
        $display("test capture done");
        // Auto-reload on rollover and on trigger
        wr(`T2CR_OFS_CTRL, 32'h00);
        wr(`T2CR_OFS_CAPREL, 32'hFFF0);
        wr(`T2CR_OFS_COUNT, 32'hFFFF);
        wr(`T2CR_OFS_CTRL, 32'h0E);
        pulse(1'b0, 1);
        rd_chk(`T2CR_OFS_COUNT, 32'hFFF0);
        rd_chk(`T2CR_OFS_STATUS, 32'h1);
        pulse(1'b0, 2);
        rd_chk(`T2CR_OFS_COUNT, 32'hFFF2);
        pulse(1'b1, 1);
        rd_chk(`T2CR_OFS_COUNT, 32'hFFF0);
        rd_chk(`T2CR_OFS_STATUS, 32'h3);
        wr(`T2CR_OFS_STATUS, 32'h3);
        $display("test reload done");
        // Baud mode for receive, transmit and both selects
        foreach (sels[i]) begin
            wr(`T2CR_OFS_CTRL, 32'h00);
            wr(`T2CR_OFS_CAPREL, 32'h1000);
            wr(`T2CR_OFS_COUNT, 32'hFFFF);
            rx0 = rx_n;
            tx0 = tx_n;
            wr(`T2CR_OFS_CTRL, {24'h0, sels[i] | 8'h0F});
            pulse(1'b0, 1);
            pulse(1'b1, 1);
            wr(`T2CR_OFS_CTRL, 32'h00);
            rd_chk(`T2CR_OFS_COUNT, 32'h1000);
            rd_chk(`T2CR_OFS_STATUS, 32'h0);
            rd_chk(`T2CR_OFS_CAPREL, 32'h1000);
            check(32'(rx_n - rx0), {31'h0, sels[i][5]});
            check(32'(tx_n - tx0), {31'h0, sels[i][4]});
        end
        $display("test baud done");
        finish_test();
    end
endmodule : t2cr_timer_tb
